// >>> src/dmc_pkg.sv
// constants, states and register layout of the motion mode controller
package dmc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] DMC_OFS_CTRL      = 8'h00;
  localparam logic [7:0] DMC_OFS_STATUS    = 8'h04;
  localparam logic [7:0] DMC_OFS_MODE_SEL  = 8'h08;
  localparam logic [7:0] DMC_OFS_MODE_DISP = 8'h0c;
  localparam logic [7:0] DMC_OFS_TVEL      = 8'h10;
  localparam logic [7:0] DMC_OFS_TPOS      = 8'h14;
  localparam logic [7:0] DMC_OFS_CFG       = 8'h18;

  // mode and configuration values
  localparam logic [7:0] DMC_MODE_PP       = 8'h01;
  localparam logic [7:0] DMC_MODE_VEL      = 8'h02;
  localparam logic [7:0] DMC_MODE_RST      = 8'h02;
  localparam logic [7:0] DMC_CFG_MOTION    = 8'h40;
  localparam logic [7:0] DMC_CFG_RST       = 8'h40;

  // control word bit positions
  localparam int DMC_CW_ENV    = 1;
  localparam int DMC_CW_NEWSP  = 4;
  localparam int DMC_CW_B5     = 5;
  localparam int DMC_CW_B6     = 6;
  localparam int DMC_CW_HALT   = 8;
  localparam int DMC_CW_B9     = 9;

  // status word bit positions
  localparam int DMC_SW_TGT    = 10;
  localparam int DMC_SW_ACK    = 12;
  localparam int DMC_SW_FERR   = 13;

  // power commands in the low nibble
  localparam logic [2:0] DMC_CMD_SHUTDOWN = 3'h6;
  localparam logic [3:0] DMC_CMD_SWON     = 4'h7;
  localparam logic [3:0] DMC_CMD_ENABLE   = 4'hf;

  // status codes of the power states
  localparam logic [15:0] DMC_SW_SOD   = 16'h0050;
  localparam logic [15:0] DMC_SW_READY = 16'h0031;
  localparam logic [15:0] DMC_SW_SWON  = 16'h0033;
  localparam logic [15:0] DMC_SW_OPEN  = 16'h0037;

  // reset values
  localparam logic [15:0] DMC_CTRL_RST = 16'h0000;
  localparam logic [15:0] DMC_TVEL_RST = 16'h0000;
  localparam logic [31:0] DMC_TPOS_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    DMC_ST_SOD   = 4'b0001,
    DMC_ST_READY = 4'b0010,
    DMC_ST_SWON  = 4'b0100,
    DMC_ST_OPEN  = 4'b1000
  } dmc_pstate_t;

  typedef struct packed {
    dmc_pstate_t pstate;
    logic [15:0] ctrl;
    logic [15:0] status;
    logic [7:0]  mode_sel;
    logic [7:0]  mode_disp;
    logic [7:0]  cfg;
    logic [15:0] tvel;
    logic [31:0] tpos;
    logic [31:0] rdata;
    logic        nsp_prev;
    logic        ack;
    logic        moving;
    logic        pend;
    logic        pend_rel;
    logic        pend_blend;
    logic [31:0] pend_pos;
    logic        op_en;
    logic        ramp_unlock;
    logic [15:0] vel_set;
    logic        vel_halt;
    logic        pos_start;
    logic [31:0] pos_target;
    logic        pos_rel;
    logic        pos_blend;
    logic        pos_halt;
  } dmc_state_t;
endpackage

// >>> src/dmc_motion_ctrl.sv
// control word interpreter for velocity and profile position modes
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01: mode-dependent bits act only in motion configuration 0x40.
// RULE_02: mode selection resets to 2, velocity mode.
// RULE_03: motion bits act only while operation enabled.
// RULE_04: mode commands refused until mode display echoes the selection.
// RULE_05: mode value 2 selects velocity mode, bits steer the ramp.
// RULE_06: velocity mode ignores control bit 4.
// RULE_07: bit 5 clear freezes speed, set lets the ramp run.
// RULE_08: bit 6 clear feeds zero set-point, set feeds target velocity.
// RULE_09: bit 8 halts the axle on deceleration ramp, staying enabled.
// RULE_10: low nibble steps power states with status 0x50, 0x31, 0x33, 0x37.
// RULE_11: velocity control words run target, run zero, or hold speed.
// RULE_12: dropping from enabled to 0x0007 stops motion; re-enable restarts.
// RULE_13: master changes modes only while switched on.
// RULE_14: mode value 1 selects profile position mode.
// RULE_15: bit 4 edge starts now with bit 5, else queues per bit 9.
// RULE_16: bit 6 selects absolute or relative target.
// RULE_17: bit 8 halts positioning with profile deceleration, staying enabled.
// RULE_18: status bit 10 shows target reached, or standstill under halt.
// RULE_19: status bit 12 is set-point acknowledge, bit 13 following error.
// RULE_20: rising bit 4 sets acknowledge and starts the move.
// RULE_21: bit 4 low clears acknowledge; no new target while acknowledged.
// RULE_22: control and status words are 16 bits, power in low nibble.
module dmc_motion_ctrl #(
  parameter logic [7:0] CFG_RESET = dmc_pkg::DMC_CFG_RST
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  // feedback from the motion core
  input  wire logic        target_reached,
  input  wire logic        axle_zero,
  input  wire logic        follow_err,
  // power state
  output var  logic        op_enabled,
  // velocity mode commands
  output var  logic        ramp_unlock,
  output var  logic [15:0] vel_setpoint,
  output var  logic        vel_halt,
  // profile position commands
  output var  logic        pos_start,
  output var  logic [31:0] pos_target,
  output var  logic        pos_relative,
  output var  logic        pos_blend,
  output var  logic        pos_halt
);
  import dmc_pkg::*;

  dmc_state_t st_reg;
  dmc_state_t st_next;

  logic        motion_cfg;
  logic        mode_ok;
  logic        vel_ok;
  logic        pp_ok;
  logic [3:0]  cmd;
  logic [15:0] cw;
  logic        nsp_rise;
  logic        accept;
  logic        go_now;
  logic        cur_done;

  // qualifiers for mode-dependent bits
  assign cw         = st_reg.ctrl;
  assign cmd        = cw[3:0]; // see RULE_22
  assign motion_cfg = (st_reg.cfg == DMC_CFG_MOTION); // see RULE_01
  assign mode_ok    = motion_cfg
                    && (st_reg.pstate == DMC_ST_OPEN) // see RULE_03
                    && (st_reg.mode_disp == st_reg.mode_sel); // see RULE_04
  assign vel_ok     = mode_ok && (st_reg.mode_disp == DMC_MODE_VEL); // see RULE_05
  assign pp_ok      = mode_ok && (st_reg.mode_disp == DMC_MODE_PP); // see RULE_14

  // new set-point handshake decode
  assign nsp_rise = pp_ok && cw[DMC_CW_NEWSP] && !st_reg.nsp_prev;
  assign accept   = nsp_rise && !st_reg.ack; // see RULE_21
  // start at once on bit 5, when idle, or when the current point ends
  // in this very cycle with nothing queued; otherwise the new point
  // would sit in the queue with no move left to release it
  assign go_now   = cw[DMC_CW_B5] // see RULE_15
                  || !st_reg.moving
                  || (cur_done && !st_reg.pend);
  assign cur_done = st_reg.moving && target_reached && !st_reg.pos_start;

  // next state of the whole block
  always_comb
  begin
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;
    st_next.pos_start = 1'b0;

    // register writes
    if (reg_wr)
    begin
      if (reg_addr == DMC_OFS_CTRL)
      begin
        st_next.ctrl = reg_wdata[15:0];
      end
      else if (reg_addr == DMC_OFS_MODE_SEL)
      begin
        st_next.mode_sel = reg_wdata[7:0];
      end
      else if (reg_addr == DMC_OFS_TVEL)
      begin
        st_next.tvel = reg_wdata[15:0];
      end
      else if (reg_addr == DMC_OFS_TPOS)
      begin
        st_next.tpos = reg_wdata;
      end
      else if (reg_addr == DMC_OFS_CFG)
      begin
        st_next.cfg = reg_wdata[7:0];
      end
    end

    // register reads, data valid the following cycle only
    if (reg_rd)
    begin
      if (reg_addr == DMC_OFS_CTRL)
      begin
        st_next.rdata = {16'h0000, st_reg.ctrl};
      end
      else if (reg_addr == DMC_OFS_STATUS)
      begin
        st_next.rdata = {16'h0000, st_reg.status};
      end
      else if (reg_addr == DMC_OFS_MODE_SEL)
      begin
        st_next.rdata = {24'h000000, st_reg.mode_sel};
      end
      else if (reg_addr == DMC_OFS_MODE_DISP)
      begin
        st_next.rdata = {24'h000000, st_reg.mode_disp};
      end
      else if (reg_addr == DMC_OFS_TVEL)
      begin
        st_next.rdata = {16'h0000, st_reg.tvel};
      end
      else if (reg_addr == DMC_OFS_TPOS)
      begin
        st_next.rdata = st_reg.tpos;
      end
      else if (reg_addr == DMC_OFS_CFG)
      begin
        st_next.rdata = {24'h000000, st_reg.cfg};
      end
    end

    // mode display echoes the selection one cycle later
    st_next.mode_disp = st_reg.mode_sel; // see RULE_04

    // power state machine from the low nibble
    if (!cmd[DMC_CW_ENV])
    begin
      st_next.pstate = DMC_ST_SOD; // see RULE_10
    end
    else
    begin
      case (st_reg.pstate)
        DMC_ST_SOD:
        begin
          if (cmd[2:0] == DMC_CMD_SHUTDOWN)
          begin
            st_next.pstate = DMC_ST_READY; // see RULE_10
          end
          // short path to enabled outside motion configuration
          else if (cmd == DMC_CMD_ENABLE && !motion_cfg)
          begin
            st_next.pstate = DMC_ST_OPEN;
          end
        end
        DMC_ST_READY:
        begin
          if (cmd == DMC_CMD_SWON)
          begin
            st_next.pstate = DMC_ST_SWON; // see RULE_10
          end
          // short path to enabled outside motion configuration
          else if (cmd == DMC_CMD_ENABLE && !motion_cfg)
          begin
            st_next.pstate = DMC_ST_OPEN;
          end
        end
        DMC_ST_SWON:
        begin
          if (cmd[2:0] == DMC_CMD_SHUTDOWN)
          begin
            st_next.pstate = DMC_ST_READY;
          end
          else if (cmd == DMC_CMD_ENABLE)
          begin
            st_next.pstate = DMC_ST_OPEN; // see RULE_10
          end
        end
        DMC_ST_OPEN:
        begin
          // enable while enabled keeps the state
          if (cmd[2:0] == DMC_CMD_SHUTDOWN)
          begin
            st_next.pstate = DMC_ST_READY;
          end
          else if (cmd == DMC_CMD_SWON)
          begin
            st_next.pstate = DMC_ST_SWON; // see RULE_12
          end
        end
        // illegal codes fall back to switch-on disabled
        default:
        begin
          st_next.pstate = DMC_ST_SOD;
        end
      endcase
    end
    // enable flag trails the power state by one cycle
    st_next.op_en = (st_reg.pstate == DMC_ST_OPEN);

    // velocity mode: bit 4 unused, 5 unlock, 6 reference, 8 halt
    st_next.ramp_unlock = vel_ok && cw[DMC_CW_B5]; // see RULE_07, RULE_11
    if (vel_ok && cw[DMC_CW_B6])
    begin
      st_next.vel_set = st_reg.tvel; // see RULE_08, RULE_11
    end
    else
    begin
      st_next.vel_set = 16'h0000; // see RULE_08
    end
    st_next.vel_halt = vel_ok && cw[DMC_CW_HALT]; // see RULE_09

    // profile position halt
    st_next.pos_halt = pp_ok && cw[DMC_CW_HALT]; // see RULE_17

    // bit 4 history, tracked always so a held bit makes no edge
    st_next.nsp_prev = cw[DMC_CW_NEWSP];

    // acknowledge drops once the master clears bit 4
    // no clash with a set: accepting needs bit 4 high
    if (!cw[DMC_CW_NEWSP])
    begin
      st_next.ack = 1'b0; // see RULE_21
    end

    if (!pp_ok)
    begin
      // leaving enabled or the mode aborts positioning
      st_next.moving = 1'b0; // see RULE_12
      st_next.pend = 1'b0;
    end
    else
    begin
      // current set-point finished: chain the queued one
      if (cur_done)
      begin
        if (st_reg.pend)
        begin
          st_next.pos_start = 1'b1; // see RULE_15
          st_next.pos_target = st_reg.pend_pos;
          st_next.pos_rel = st_reg.pend_rel;
          st_next.pend = 1'b0;
        end
        else
        begin
          st_next.moving = 1'b0;
        end
      end
      // a new valid set-point is taken over
      if (accept)
      begin
        st_next.ack = 1'b1; // see RULE_20
        if (go_now)
        begin
          st_next.pos_start = 1'b1; // see RULE_15
          st_next.pos_target = st_reg.tpos;
          st_next.pos_rel = cw[DMC_CW_B6]; // see RULE_16
          st_next.moving = 1'b1;
          st_next.pend = 1'b0;
        end
        else
        begin
          st_next.pend = 1'b1; // see RULE_15
          st_next.pend_pos = st_reg.tpos;
          st_next.pend_rel = cw[DMC_CW_B6]; // see RULE_16
          st_next.pend_blend = cw[DMC_CW_B9];
        end
      end
    end
    // queued point chained at speed when bit 9 was set
    st_next.pos_blend = st_next.pend && st_next.pend_blend; // see RULE_15

    // status word: power code plus mode-specific flags
    // built from the state being entered, so it leads op_enabled
    case (st_next.pstate)
      DMC_ST_SOD:   st_next.status = DMC_SW_SOD;
      DMC_ST_READY: st_next.status = DMC_SW_READY;
      DMC_ST_SWON:  st_next.status = DMC_SW_SWON;
      default:      st_next.status = DMC_SW_OPEN;
    endcase
    if (motion_cfg)
    begin
      // see RULE_18
      st_next.status[DMC_SW_TGT] = cw[DMC_CW_HALT] ? axle_zero
                                                   : target_reached;
      if (st_reg.mode_disp == DMC_MODE_PP)
      begin
        st_next.status[DMC_SW_ACK]  = st_next.ack; // see RULE_19
        st_next.status[DMC_SW_FERR] = follow_err; // see RULE_19
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '{
        pstate:      DMC_ST_SOD,
        ctrl:        DMC_CTRL_RST,
        status:      DMC_SW_SOD,
        mode_sel:    DMC_MODE_RST, // see RULE_02
        mode_disp:   DMC_MODE_RST,
        cfg:         CFG_RESET,
        tvel:        DMC_TVEL_RST,
        tpos:        DMC_TPOS_RST,
        rdata:       32'h0000_0000,
        nsp_prev:    1'b0,
        ack:         1'b0,
        moving:      1'b0,
        pend:        1'b0,
        pend_rel:    1'b0,
        pend_blend:  1'b0,
        pend_pos:    32'h0000_0000,
        op_en:       1'b0,
        ramp_unlock: 1'b0,
        vel_set:     16'h0000,
        vel_halt:    1'b0,
        pos_start:   1'b0,
        pos_target:  32'h0000_0000,
        pos_rel:     1'b0,
        pos_blend:   1'b0,
        pos_halt:    1'b0
      };
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign reg_rdata    = st_reg.rdata;
  assign op_enabled   = st_reg.op_en;
  assign ramp_unlock  = st_reg.ramp_unlock;
  assign vel_setpoint = st_reg.vel_set;
  assign vel_halt     = st_reg.vel_halt;
  assign pos_start    = st_reg.pos_start;
  assign pos_target   = st_reg.pos_target;
  assign pos_relative = st_reg.pos_rel;
  assign pos_blend    = st_reg.pos_blend;
  assign pos_halt     = st_reg.pos_halt;
endmodule

`default_nettype wire

// >>> bench/dmc_motion_ctrl_properties.sv
// port assertions for the motion mode controller
`timescale 1ns/1ps
`default_nettype none
module dmc_motion_ctrl_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register read port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // command outputs
  input wire logic        op_enabled,
  input wire logic        ramp_unlock,
  input wire logic        vel_halt,
  input wire logic        pos_start,
  input wire logic [31:0] pos_target,
  input wire logic        pos_halt
);
  import dmc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // read data live one cycle only, the control word is 16 bits wide
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> !reg_rdata)
    else $error("read data outside a read cycle");
  AST_CW_WIDTH: assert property (
    reg_rd && reg_addr == DMC_OFS_CTRL |=> reg_rdata[31:16] == 16'h0)
    else $error("control word wider than 16 bits");
  // status power code agrees with the enable output
  AST_ST_POWER: assert property (
    reg_rd && reg_addr == DMC_OFS_STATUS
    |=> (reg_rdata[6:0] == 7'h37) == op_enabled)
    else $error("status power code disagrees with enable");
  // start is a pulse, its target holds between starts
  AST_START_PULSE: assert property (pos_start |=> !pos_start)
    else $error("start longer than one cycle");
  AST_TGT_HOLD: assert property (!pos_start |-> $stable(pos_target))
    else $error("target moved without a start");
  // motion commands only while operation is enabled
  AST_START_EN: assert property (pos_start |-> op_enabled)
    else $error("start outside operation enabled");
  AST_RAMP_EN: assert property (
    ramp_unlock |-> ##[0:1] op_enabled)
    else $error("ramp unlocked while not enabled");
  AST_HALT_EN: assert property (
    vel_halt || pos_halt |-> ##[0:1] op_enabled)
    else $error("halt active while not enabled");
endmodule

bind dmc_motion_ctrl dmc_motion_ctrl_chk u_chk (
  .core_clk, .rst, .reg_addr, .reg_rd, .reg_rdata, .op_enabled,
  .ramp_unlock, .vel_halt, .pos_start, .pos_target, .pos_halt
);
`default_nettype wire

// >>> bench/dmc_core_model.sv
// behavioural motion core answering the controller
`timescale 1ns/1ps
`default_nettype none
module dmc_core_model #(
  parameter int TRAVEL = 6,
  parameter int DECEL  = 8
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // commands
  input  wire logic pos_start,
  input  wire logic pos_halt,
  input  wire logic vel_halt,
  // bench controls
  input  wire logic slow,
  input  wire logic ferr_req,
  // feedback
  output var  logic target_reached,
  output var  logic axle_zero,
  output var  logic follow_err
);
  int cnt;
  int hz;
  // travel and deceleration counters
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      hz  <= 0;
    end
    else
    begin
      cnt <= pos_start ? (slow ? 8 * TRAVEL : TRAVEL) : (cnt > 0 ? cnt - 1 : 0);
      hz  <= (pos_halt || vel_halt) ? (hz < DECEL ? hz + 1 : hz) : 0;
    end
  end
  // reached drops as soon as a move starts
  assign target_reached = (cnt == 0) && !pos_start;
  assign axle_zero      = (hz == DECEL) || (cnt == 0);
  assign follow_err     = ferr_req;
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the motion mode controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dmc_pkg::*;
  logic        core_clk, rst, reg_wr, reg_rd, slow, ferr_req;
  logic        target_reached, axle_zero, follow_err, op_enabled;
  logic        ramp_unlock, vel_halt, pos_start, pos_relative;
  logic        pos_blend, pos_halt;
  logic [7:0]  reg_addr;
  logic [15:0] vel_setpoint;
  logic [31:0] reg_wdata, reg_rdata, pos_target, rd_val, tv;
  logic [31:0] starts[$];
  logic [15:0] vcodes[7] = '{16'h007f, 16'h006f, 16'h003f, 16'h002f,
                             16'h005f, 16'h004f, 16'h017f};
  int          bad_count;
  int          check_count;

  dmc_motion_ctrl dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .target_reached, .axle_zero, .follow_err,
    .op_enabled, .ramp_unlock, .vel_setpoint, .vel_halt, .pos_start,
    .pos_target, .pos_relative, .pos_blend, .pos_halt);
  dmc_core_model core (.core_clk, .rst, .pos_start, .pos_halt, .vel_halt,
    .slow, .ferr_req, .target_reached, .axle_zero, .follow_err);

  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hffffffff);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    rd_val = reg_rdata;
    chk(rd_val & m, e);
  endtask
  task automatic cw(input logic [15:0] v);
    wr(DMC_OFS_CTRL, {16'h0, v});
    repeat (3) @(posedge core_clk);
  endtask

  // load a target, raise the new set-point bit, count pending starts
  task automatic seg(input logic [15:0] c, input int pend);
    tv = $urandom;
    wr(DMC_OFS_TPOS, tv);
    starts.push_back(tv);
    cw(c);
    @(posedge core_clk);
    chk(starts.size(), pend);
    rchk(DMC_OFS_STATUS, 32'h1000, 32'h1000);
  endtask
  task automatic drain();
    int n = 0;
    while (starts.size() > 0 && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    if (starts.size() > 0)
    begin
      bad_count++;
      final_report();
    end
  endtask

  // every start must carry the oldest pending target
  always @(posedge core_clk)
    if (!rst && pos_start === 1'b1)
    begin
      if (starts.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(pos_target, starts.pop_front());
    end

  // main sequence
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slow = 1'b0;
    ferr_req = 1'b0;
    bad_count = 0;
    check_count = 0;
    tv = $urandom(32'hbfaecdd2);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rchk(DMC_OFS_MODE_SEL, 32'h2);
    rchk(DMC_OFS_MODE_DISP, 32'h2);
    rchk(DMC_OFS_STATUS, 32'h0450);
    rchk(8'h20, 32'h0);
    // power-up walk
    cw(16'h0006);
    rchk(DMC_OFS_STATUS, 32'h0431);
    cw(16'h0007);
    rchk(DMC_OFS_STATUS, 32'h0433);
    cw(16'h000f);
    cw(16'h000f);
    rchk(DMC_OFS_STATUS, 32'h0437);
    rchk(DMC_OFS_CTRL, 32'h000f);
    // velocity control words
    tv = {16'h0, 16'($urandom) | 16'h1};
    wr(DMC_OFS_TVEL, tv);
    foreach (vcodes[i])
    begin
      cw(vcodes[i]);
      chk(ramp_unlock, vcodes[i][5]);
      chk(vel_setpoint, vcodes[i][6] ? tv : 32'h0);
      chk(vel_halt, vcodes[i][8]);
      chk(op_enabled, 1'b1);
    end
    cw(16'h0007);
    chk(ramp_unlock, 1'b0);
    chk(op_enabled, 1'b0);
    cw(16'h007f);
    chk(ramp_unlock, 1'b1);
    // mode change while switched on
    cw(16'h0007);
    rchk(DMC_OFS_STATUS, 32'h33, 32'hff);
    wr(DMC_OFS_MODE_SEL, 32'h1);
    rchk(DMC_OFS_MODE_DISP, 32'h1);
    cw(16'h000f);
    // absolute and relative targets with handshake
    seg(16'h001f, 0);
    chk(pos_relative, 1'b0);
    cw(16'h000f);
    rchk(DMC_OFS_STATUS, 32'h0, 32'h1000);
    seg(16'h005f, 0);
    chk(pos_relative, 1'b1);
    cw(16'h000f);
    repeat (10) @(posedge core_clk);
    rchk(DMC_OFS_STATUS, 32'h0400, 32'h0400);
    // immediate change, then a queued blended point
    slow <= 1'b1;
    seg(16'h001f, 0);
    cw(16'h000f);
    seg(16'h003f, 0);
    cw(16'h000f);
    seg(16'h021f, 1);
    chk(pos_blend, 1'b1);
    drain();
    // halt during a move: bit 10 low while braking, high at standstill
    cw(16'h000f);
    seg(16'h003f, 0);
    cw(16'h013f);
    chk(pos_halt, 1'b1);
    chk(op_enabled, 1'b1);
    rchk(DMC_OFS_STATUS, 32'h0000, 32'h0400);
    repeat (10) @(posedge core_clk);
    rchk(DMC_OFS_STATUS, 32'h0400, 32'h0400);
    ferr_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    rchk(DMC_OFS_STATUS, 32'h2000, 32'h2000);
    ferr_req <= 1'b0;
    // no start outside the motion configuration
    cw(16'h000f);
    wr(DMC_OFS_CFG, 32'h0);
    cw(16'h001f);
    repeat (5) @(posedge core_clk);
    // second reset restores velocity mode
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rchk(DMC_OFS_MODE_SEL, 32'h2);
    chk(starts.size(), 0);
    final_report();
  end
endmodule
`default_nettype wire
